// *** hdl/fault_interrupt_flags.sv ***
`timescale 1ns/100ps
`include "fault_irq_params.svh"

module fault_interrupt_flags
	import fault_irq_pkg::*;
#(
	parameter int LINREG_COUNT = 6
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access port from the serial interface
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire fault_irq_pkg::reg_addr_t reg_addr,
	input wire fault_irq_pkg::reg_byte_t reg_wdata,
	output fault_irq_pkg::reg_byte_t reg_rdata,
	output logic reg_rvalid,
	// Raw fault and OTP conditions, asynchronous
	input wire logic otp_error_in,
	input wire logic fuse_burn_running_in,
	input wire logic boost_overcurrent_in,
	input wire logic [LINREG_COUNT-1:0] linreg_overcurrent_in,
	// Interrupt pin, low active
	output logic irq_out_n
);
	import fault_irq_pkg::*;

	localparam int NSRC = LINREG_COUNT + 3;

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [NSRC-1:0] raw_all;
	logic [NSRC-1:0] live_all;
	logic [NSRC-1:0] rise_all;
	logic burn_fall;

	// Source order: otp, burn, boost, then regulators from bit 3 up
	assign raw_all = {linreg_overcurrent_in, boost_overcurrent_in,
		fuse_burn_running_in, otp_error_in};

	edge_sync #(.WIDTH(NSRC)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.raw_in(raw_all),
		.level_out(live_all),
		.rise_out(rise_all)
	);

	// ****************************************************************
	// Core state
	// ****************************************************************
	typedef struct packed {
		irq_state_t phase;
		logic [2:0] settle;
		reg_byte_t mask3;
		logic otp_err_flag;
		logic burn_done_flag;
		logic boost_flag;
		linreg_vec_t linreg_flags;
		logic burn_prev;
		reg_byte_t rdata;
		logic rvalid;
		logic irq_n;
	} core_state_t;

	core_state_t st_r;
	core_state_t st_nxt;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Decode: true when a write hits the given offset
	function automatic logic wr_hit(input reg_addr_t ofs);
		return reg_wr && (reg_addr == ofs);
	endfunction

	// Completion is the falling edge of the running indication
	assign burn_fall = st_r.burn_prev & ~live_all[1];

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		reg_byte_t sense3;
		reg_byte_t stat3;
		reg_byte_t wclr;
		logic pend;
		sense3 = `RST_ZERO;
		stat3 = `RST_ZERO;
		wclr = reg_wdata;
		pend = 1'b0;
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.burn_prev = live_all[1];

		// Live view, unlatched
		sense3[`BIT_OTP_ERROR] = live_all[0];
		sense3[`BIT_FUSE_BURN] = live_all[1];
		sense3[`BIT_BOOST_OC] = live_all[2];
		stat3[`BIT_OTP_ERROR] = st_r.otp_err_flag;
		stat3[`BIT_FUSE_BURN] = st_r.burn_done_flag;
		stat3[`BIT_BOOST_OC] = st_r.boost_flag;

		case (st_r.phase)
			ST_RESET: begin
				st_nxt.phase = ST_PRIME;
				st_nxt.settle = '0;
			end
			ST_PRIME: begin
				// Hold off until the sync pipe and its edge pulse have
				// drained; a level already present at reset would
				// otherwise look like a fresh edge
				if (st_r.settle == `SYNC_SETTLE_LAST) begin
					st_nxt.phase = ST_RUN;
				end else begin
					st_nxt.settle = st_r.settle + 3'd1;
				end
			end
			ST_RUN: begin
				// Mask write; unimplemented bits keep fixed defaults
				if (wr_hit(`OFS_GROUP3_INTERRUPT_MASK)) begin
					st_nxt.mask3 = (reg_wdata & `GROUP3_IMPL_BITS)
						| `GROUP3_FIXED_BITS;
				end
				// Write-1 clears, then sets override
				if (wr_hit(`OFS_GROUP3_STATUS)) begin
					st_nxt.otp_err_flag = st_r.otp_err_flag
						& ~wclr[`BIT_OTP_ERROR];
					st_nxt.burn_done_flag = st_r.burn_done_flag
						& ~wclr[`BIT_FUSE_BURN];
					st_nxt.boost_flag = st_r.boost_flag
						& ~wclr[`BIT_BOOST_OC];
				end
				if (wr_hit(`OFS_REGULATOR_FAULT_STATUS)) begin
					st_nxt.linreg_flags = st_r.linreg_flags
						& ~wclr[5:0];
				end
				// Edge-triggered sets
				if (rise_all[0]) st_nxt.otp_err_flag = 1'b1;
				if (burn_fall) st_nxt.burn_done_flag = 1'b1;
				if (rise_all[2]) st_nxt.boost_flag = 1'b1;
				st_nxt.linreg_flags = st_nxt.linreg_flags
					| rise_all[NSRC-1:3];
			end
			default: begin
				st_nxt.phase = ST_RESET;
			end
		endcase

		// Read mux; writes to the sense offset fall through
		if (reg_rd) begin
			st_nxt.rvalid = 1'b1;
			case (reg_addr)
				`OFS_GROUP3_INTERRUPT_MASK: st_nxt.rdata = st_r.mask3;
				`OFS_GROUP3_STATUS: st_nxt.rdata = stat3;
				`OFS_GROUP3_LIVE_SENSE: st_nxt.rdata = sense3;
				`OFS_REGULATOR_FAULT_STATUS: begin
					st_nxt.rdata = {2'b00, st_r.linreg_flags};
				end
				default: st_nxt.rdata = `RST_ZERO;
			endcase
		end

		// Pin: any unmasked pending flag pulls it low
		// Regulator flags carry no mask in this block, so any one counts
		pend = (st_nxt.otp_err_flag & ~st_nxt.mask3[`BIT_OTP_ERROR])
			| (st_nxt.burn_done_flag & ~st_nxt.mask3[`BIT_FUSE_BURN])
			| (st_nxt.boost_flag & ~st_nxt.mask3[`BIT_BOOST_OC])
			| (|st_nxt.linreg_flags);
		st_nxt.irq_n = ~pend;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset: masks set, flags clear, pin released
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r.phase <= ST_RESET;
			st_r.settle <= '0;
			st_r.mask3 <= `RST_GROUP3_MASK_BITS;
			st_r.otp_err_flag <= 1'b0;
			st_r.burn_done_flag <= 1'b0;
			st_r.boost_flag <= 1'b0;
			st_r.linreg_flags <= '0;
			st_r.burn_prev <= 1'b0;
			st_r.rdata <= `RST_ZERO;
			st_r.rvalid <= 1'b0;
			st_r.irq_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every port comes straight from the state register
	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign irq_out_n = st_r.irq_n;
endmodule // fault_interrupt_flags

// *** hdl/fault_irq_params.svh ***
`ifndef FAULT_IRQ_PARAMS_SVH
`define FAULT_IRQ_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_GROUP3_INTERRUPT_MASK 8'h0F
`define OFS_GROUP3_STATUS 8'h0E
`define OFS_GROUP3_LIVE_SENSE 8'h10
`define OFS_REGULATOR_FAULT_STATUS 8'h11

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_OTP_ERROR 7
`define BIT_FUSE_BURN 6
`define BIT_BOOST_OC 0

// ****************************************************************
// Reset values and fixed bits
// ****************************************************************
`define RST_GROUP3_MASK_BITS 8'hC5
`define GROUP3_IMPL_BITS 8'hC1
`define GROUP3_FIXED_BITS 8'h04
`define FAULT_STATUS_IMPL 8'h3F
`define RST_ZERO 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
// Last count of the startup hold-off, long enough for the sync pipe
// and its one-cycle edge pulse to drain after reset
`define SYNC_SETTLE_LAST 3'd4

`endif

// *** hdl/fault_irq_pkg.sv ***
package fault_irq_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [7:0] reg_addr_t;
	typedef logic [5:0] linreg_vec_t;
	// Startup sequencing of the flag logic
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_PRIME = 2'b01,
		ST_RUN = 2'b11
	} irq_state_t;
endpackage

// *** hdl/edge_sync.sv ***
`timescale 1ns/100ps
`include "fault_irq_params.svh"

// Three-stage input synchroniser with agreement filter and rising edge
module edge_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Raw asynchronous inputs
	input wire logic [WIDTH-1:0] raw_in,
	// Filtered level and one-cycle rising pulse
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
		logic [WIDTH-1:0] rise;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// Level only moves once stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = raw_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
		st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
	end

	// Register stage; reset clears every stage, so a level held across reset still gives a rise pulse
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.lvl;
	assign rise_out = st_r.rise;
endmodule // edge_sync

// *** testbench/fault_irq_monitor.sv ***
`timescale 1ns/100ps
// ****
// Port checks
// ****
module fault_irq_monitor
	import fault_irq_pkg::*;
#(
	parameter int LINREG_COUNT = 6
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire fault_irq_pkg::reg_addr_t reg_addr,
	input wire fault_irq_pkg::reg_byte_t reg_wdata,
	input wire fault_irq_pkg::reg_byte_t reg_rdata,
	input wire logic reg_rvalid,
	// Conditions and pin
	input wire logic otp_error_in,
	input wire logic fuse_burn_running_in,
	input wire logic boost_overcurrent_in,
	input wire logic [LINREG_COUNT-1:0] linreg_overcurrent_in,
	input wire logic irq_out_n
);
	// One domain, so clock and reset are set once
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_rd_answered: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	chk_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("stray read valid");
	chk_wr_silent: assert property (reg_wr && !reg_rd |=> !reg_rvalid)
		else $error("write gave read valid");
	chk_mask_fixed: assert property (reg_rd && reg_addr == 8'h0F
		|=> reg_rdata[5:1] == 5'h02) else $error("mask fixed bits");
	chk_stat_rsvd: assert property (reg_rd && reg_addr == 8'h11
		|=> reg_rdata[7:6] == 2'h0) else $error("status reserved bits");
	chk_sense_rsvd: assert property (reg_rd && reg_addr == 8'h10
		|=> reg_rdata[5:1] == 5'h00) else $error("sense reserved bits");
	chk_lin_pin: assert property ($rose(linreg_overcurrent_in[0])
		|-> ##[2:8] !irq_out_n) else $error("no interrupt on fault");
	chk_rdata_hold: assert property (!$past(reg_rd)
		|-> $stable(reg_rdata)) else $error("read data moved");
endmodule // fault_irq_monitor

// *** testbench/host_model.sv ***
`timescale 1ns/100ps
// ****
// Host on the register port
// ****
module host_model
	import fault_irq_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output fault_irq_pkg::reg_addr_t reg_addr,
	output fault_irq_pkg::reg_byte_t reg_wdata,
	input wire fault_irq_pkg::reg_byte_t reg_rdata
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One byte; fuse bank regs are never touched
	task automatic wr(input reg_addr_t a, input reg_byte_t d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a; // Released bus shows junk
		reg_wdata <= ~d;
	endtask
	// Data lands on the edge that takes the strobe
	task automatic rd(input reg_addr_t a, output reg_byte_t d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
endmodule // host_model

// *** testbench/test_fault_interrupt_flags.sv ***
`timescale 1ns/100ps
module test_fault_interrupt_flags;
	import fault_irq_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, reg_rvalid, irq_out_n;
	logic otp_error_in, fuse_burn_running_in, boost_overcurrent_in;
	logic [5:0] linreg_overcurrent_in;
	reg_addr_t reg_addr;
	reg_byte_t reg_wdata, reg_rdata, v;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	fault_interrupt_flags u_dut (.core_clk, .rst, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .otp_error_in,
		.fuse_burn_running_in, .boost_overcurrent_in,
		.linreg_overcurrent_in, .irq_out_n);
	host_model u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata);
	task automatic chk(string nm, reg_byte_t seen, reg_byte_t exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Boost already in limit at reset: sense shows it, no flag
	task automatic t_reset;
		u_host.rd(8'h0F, v);
		chk("mask", v, 8'hC5);
		u_host.rd(8'h10, v);
		chk("sense", v, 8'h01);
		u_host.rd(8'h11, v);
		chk("status", v, 8'h00);
		u_host.rd(8'h0E, v);
		chk("startup flags", v, 8'h00);
		chk("pin", {7'h00, irq_out_n}, 8'h01);
	endtask
	task automatic t_sense;
		@(posedge core_clk);
		otp_error_in <= 1'b1;
		fuse_burn_running_in <= 1'b1;
		boost_overcurrent_in <= 1'b0;
		repeat (8) @(posedge core_clk);
		u_host.wr(8'h10, 8'hFF);
		u_host.rd(8'h10, v);
		chk("live", v, 8'hC0);
		@(posedge core_clk);
		otp_error_in <= 1'b0;
		fuse_burn_running_in <= 1'b0;
		boost_overcurrent_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		u_host.rd(8'h10, v);
		chk("live", v, 8'h01);
		u_host.rd(8'h0E, v);
		chk("g3 flags", v, 8'hC1);
		chk("masked pin", {7'h00, irq_out_n}, 8'h01);
	endtask
	// Unmask one flag at a time, then clear them all
	task automatic t_mask;
		for (int b = 0; b < 8; b++) begin
			if (b == 7 || b == 6 || b == 0) begin
				u_host.wr(8'h0F, 8'hC1 ^ (8'h01 << b));
				u_host.rd(8'h0F, v);
				chk("mask", v, 8'hC5 ^ (8'h01 << b));
				chk("pin", {7'h00, irq_out_n}, 8'h00);
				u_host.wr(8'h0F, 8'hC1);
			end
		end
		u_host.wr(8'h0E, 8'hC1);
		u_host.rd(8'h0E, v);
		chk("g3 clear", v, 8'h00);
	endtask
	// Each regulator: flag, pin, write 0 keeps, write 1 clears
	task automatic t_lin;
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			linreg_overcurrent_in <= 6'h01 << i;
			repeat (8) @(posedge core_clk);
			chk("pin", {7'h00, irq_out_n}, 8'h00);
			u_host.wr(8'h11, 8'hC0);
			u_host.rd(8'h11, v);
			chk("lin", v, 8'h01 << i);
			u_host.wr(8'h11, 8'hFF);
			u_host.rd(8'h11, v);
			chk("lin clr", v, 8'h00);
		end
	endtask
	// Clear lands on the edge of a fresh set; the set must survive
	task automatic t_race;
		@(posedge core_clk);
		linreg_overcurrent_in <= 6'h01;
		repeat (3) @(posedge core_clk); // Flag sets 5 edges after the pin
		u_host.wr(8'h11, 8'hFF);
		u_host.rd(8'h11, v);
		chk("set wins", v, 8'h01);
	endtask
	initial begin
		rst = 1'b1;
		otp_error_in = 1'b0;
		fuse_burn_running_in = 1'b0;
		boost_overcurrent_in = 1'b1;
		linreg_overcurrent_in = 6'h00;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_sense;
		t_mask;
		t_lin;
		t_race;
		results;
	end
	// Cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			results;
		end
	end
endmodule // test_fault_interrupt_flags
bind fault_interrupt_flags fault_irq_monitor #(
	.LINREG_COUNT(LINREG_COUNT)) u_mon (.core_clk, .rst, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
	.otp_error_in, .fuse_burn_running_in, .boost_overcurrent_in,
	.linreg_overcurrent_in, .irq_out_n);
